// >>> include/ctc_regs.svh
/*
  Register offsets, field positions, reset values and decode constants
  of the charge threshold configuration bank.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CTC_REGS_SVH
`define CTC_REGS_SVH

// ----------------------------------------------------------------
// register offsets (management port pointer values)
// ----------------------------------------------------------------
`define CTC_OFS_PRECHG_TERM 8'h03
`define CTC_OFS_CHG_VOLT 8'h04
`define CTC_OFS_TERM_TIMER 8'h05

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTC_RST_PRECHG_TERM 8'h11
`define CTC_RST_CHG_VOLT_STD 8'hB2
`define CTC_RST_CHG_VOLT_RED 8'h9A
`define CTC_RST_TERM_TIMER 8'h9A

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTC_PRECHG_MSB 7
`define CTC_PRECHG_LSB 4
`define CTC_TERM_MSB 3
`define CTC_TERM_LSB 0
`define CTC_RVOLT_MSB 7
`define CTC_RVOLT_LSB 2
`define CTC_BATLOW_BIT 1
`define CTC_RECHG_BIT 0
`define CTC_TERM_EN_BIT 7
`define CTC_EARLY_STAT_BIT 6
`define CTC_WDOG_MSB 5
`define CTC_WDOG_LSB 4
`define CTC_TIMER_EN_BIT 3
`define CTC_TIMER_MSB 2
`define CTC_TIMER_LSB 1
`define CTC_RSVD_BIT 0

// ----------------------------------------------------------------
// decode constants
// ----------------------------------------------------------------
`define CTC_CUR_OFFSET_MA 12'h080
`define CTC_CUR_STEP_MA 12'h080
`define CTC_PRECHG_RED_MAX 4'h4
`define CTC_RVOLT_OFFSET_MV 13'h0DB0
`define CTC_RVOLT_STEP_MV 13'h0010
`define CTC_RVOLT_MAX_CODE 6'h38
`define CTC_BATLOW_LO_MV 12'hAF0
`define CTC_BATLOW_HI_MV 12'hBB8
`define CTC_RECHG_LO_MV 13'h0064
`define CTC_RECHG_HI_MV 13'h012C
`define CTC_EARLY_STAT_MA 12'h320
`define CTC_WDOG_OFF_S 8'h00
`define CTC_WDOG_40_S 8'h28
`define CTC_WDOG_80_S 8'h50
`define CTC_WDOG_160_S 8'hA0
`define CTC_TIMER_5_H 5'h05
`define CTC_TIMER_8_H 5'h08
`define CTC_TIMER_12_H 5'h0C
`define CTC_TIMER_20_H 5'h14

// ----------------------------------------------------------------
// management port
// ----------------------------------------------------------------
`define CTC_I2C_ADDR_DFLT 7'h2A
`define CTC_BYTE_BITS 4'h8

`endif

// >>> include/ctc_pkg.sv
/*
  Types of the charge threshold configuration bank.
  Assumes ctc_regs.svh on the include path.
*/
package ctc_pkg;

  typedef enum logic [2:0] {
    CTC_IDLE = 3'b000,
    CTC_ADDR = 3'b001,
    CTC_ADDR_ACK = 3'b010,
    CTC_PTR = 3'b011,
    CTC_PTR_ACK = 3'b100,
    CTC_WDATA = 3'b101,
    CTC_WDATA_ACK = 3'b110,
    CTC_RDATA = 3'b111
  } ctc_state_e;

  typedef struct packed {
    ctc_state_e state;
    logic rd_ack;
    logic scl;
    logic sda;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic rw;
    logic nack;
    logic [7:0] ptr;
    logic sda_oe;
    logic [7:0] prechg_term;
    logic [7:0] chg_volt;
    logic [7:0] term_timer;
  } ctc_top_s;

  typedef struct packed {
    logic [11:0] prechg_ma;
    logic [11:0] term_ma;
    logic [12:0] rvolt_mv;
    logic [11:0] batlow_mv;
    logic [12:0] rechg_mv;
    logic term_en;
    logic [11:0] stat_ma;
    logic [7:0] wdog_s;
    logic timer_en;
    logic [4:0] timer_h;
  } ctc_dec_s;

endpackage : ctc_pkg

// >>> include/ctc_cfg_if.sv
/*
  Carries the three configuration bytes from the register bank to the decoder.
  Assumes both ends share one clock.
*/
`timescale 1ns/100ps
interface ctc_cfg_if;
  logic [7:0] prechg_term;
  logic [7:0] chg_volt;
  logic [7:0] term_timer;
  modport src (output prechg_term, output chg_volt, output term_timer);
  modport dst (input prechg_term, input chg_volt, input term_timer);
endinterface : ctc_cfg_if

// >>> logic/ctc_cfg_decode.sv
/*
  Turns the configuration bytes into physical set points for the analog loops.
  Assumes the bytes are stable flop outputs of the register bank.
*/
`timescale 1ns/100ps
`include "ctc_regs.svh"
module ctc_cfg_decode #(
  parameter bit REDUCED_VARIANT = 1'b0
) (
  input wire logic ref_clk_i,              // system clock
  input wire logic srst_i,                 // sync reset, high
  ctc_cfg_if.dst cfg,                      // configuration bytes
  output ctc_pkg::ctc_dec_s dec_o          // registered set points
);

  ctc_pkg::ctc_dec_s dec_q;
  ctc_pkg::ctc_dec_s dec_d;
  logic [3:0] pre_code;
  logic [5:0] rvolt_code;

  always_comb begin
    dec_d = dec_q;
    pre_code = cfg.prechg_term[`CTC_PRECHG_MSB:`CTC_PRECHG_LSB];
    if (REDUCED_VARIANT && (pre_code > `CTC_PRECHG_RED_MAX)) begin
      pre_code = `CTC_PRECHG_RED_MAX;                                           // R4
    end
    dec_d.prechg_ma = 12'(pre_code) * `CTC_CUR_STEP_MA + `CTC_CUR_OFFSET_MA;     // R3
    dec_d.term_ma = 12'(cfg.prechg_term[`CTC_TERM_MSB:`CTC_TERM_LSB]) * `CTC_CUR_STEP_MA
                    + `CTC_CUR_OFFSET_MA;                                        // R5
    rvolt_code = cfg.chg_volt[`CTC_RVOLT_MSB:`CTC_RVOLT_LSB];
    if (rvolt_code > `CTC_RVOLT_MAX_CODE) begin
      rvolt_code = `CTC_RVOLT_MAX_CODE;                                          // R7
    end
    dec_d.rvolt_mv = 13'(rvolt_code) * `CTC_RVOLT_STEP_MV + `CTC_RVOLT_OFFSET_MV; // R7
    dec_d.batlow_mv = cfg.chg_volt[`CTC_BATLOW_BIT] ? `CTC_BATLOW_HI_MV : `CTC_BATLOW_LO_MV; // R9
    dec_d.rechg_mv = dec_d.rvolt_mv
                     - (cfg.chg_volt[`CTC_RECHG_BIT] ? `CTC_RECHG_HI_MV : `CTC_RECHG_LO_MV); // R10
    dec_d.term_en = cfg.term_timer[`CTC_TERM_EN_BIT];
    // with early status bit 6 set, the early indication threshold replaces the termination threshold
    dec_d.stat_ma = cfg.term_timer[`CTC_EARLY_STAT_BIT] ? `CTC_EARLY_STAT_MA : dec_d.term_ma; // R17
    case (cfg.term_timer[`CTC_WDOG_MSB:`CTC_WDOG_LSB])
      2'h0: dec_d.wdog_s = `CTC_WDOG_OFF_S;                                      // R14
      2'h1: dec_d.wdog_s = `CTC_WDOG_40_S;
      2'h2: dec_d.wdog_s = `CTC_WDOG_80_S;
      default: dec_d.wdog_s = `CTC_WDOG_160_S;
    endcase
    dec_d.timer_en = cfg.term_timer[`CTC_TIMER_EN_BIT];
    case (cfg.term_timer[`CTC_TIMER_MSB:`CTC_TIMER_LSB])
      2'h0: dec_d.timer_h = `CTC_TIMER_5_H;                                      // R15
      2'h1: dec_d.timer_h = `CTC_TIMER_8_H;
      2'h2: dec_d.timer_h = `CTC_TIMER_12_H;
      default: dec_d.timer_h = `CTC_TIMER_20_H;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      dec_q <= '0;
    end else begin
      dec_q <= dec_d;
    end
  end

  assign dec_o = dec_q;

endmodule : ctc_cfg_decode

// >>> logic/ctc_charge_cfg.sv
/*
  Charge threshold configuration bank behind an I2C target port, with
  decoded set points for the charger loops.
  Assumes scl and sda are already synchronous to ref_clk_i and that the
  board resolves the open-drain sda wire from sda_oe_o.
*/
`timescale 1ns/100ps
`include "ctc_regs.svh"
// Operation
// R1: pre-charge/termination register resets to 0x11, 256 mA both fields.
// R2: pre-charge limit bits 7:4, termination limit bits 3:0, all read/write.
// R3: pre-charge limit is 128 mA offset plus 128 mA per code step.
// R4: reduced variant caps usable pre-charge limit at code 0100, 640 mA.
// R5: termination limit is 128 mA offset plus 128 mA steps, to 2048 mA.
// R6: voltage register: regulation code 7:2, pre-charge threshold bit 1, recharge bit 0.
// R7: regulation voltage is 3.504 V plus 16 mV steps, top code 111000.
// R8: voltage register resets to 0xB2 standard, 0x9A reduced variant.
// R9: threshold select picks 2.8 V cleared, 3.0 V set, resets to one.
// R10: recharge select is 100 mV or 300 mV below regulation, resets zero.
// R11: termination/timer register resets to 0x9A.
// R12: term enable 7, early status 6, watchdog 5:4, timer enable 3, period 2:1, reserved 0.
// R13: every bit of all three registers is plain read/write.
// R14: watchdog code: off, 40 s, 80 s, 160 s; default 01.
// R15: timer code: 5, 8, 12, 20 hours; default 01.
// R16: host always writes zero to reserved bit 0 of termination/timer.
// R17: early status set uses 800 mA indication threshold, else termination threshold.
// R18: a read returns the last written value or the reset value.
module ctc_charge_cfg #(
  parameter logic [6:0] I2C_ADDR = `CTC_I2C_ADDR_DFLT,  // arbitrary target address
  parameter bit REDUCED_VARIANT = 1'b0
) (
  input wire logic ref_clk_i,              // 20 MHz clock
  input wire logic srst_i,                 // sync reset, high
  input wire logic scl_i,                  // i2c clock in
  input wire logic sda_i,                  // i2c data in
  output logic sda_o,                      // i2c data out, always low
  output logic sda_oe_o,                   // pull sda low when high
  output logic [7:0] prechg_term_o,        // raw pre-charge/termination byte
  output logic [7:0] chg_volt_o,           // raw charge voltage byte
  output logic [7:0] term_timer_o,         // raw termination/timer byte
  output logic [11:0] precharge_current_limit_o,   // mA
  output logic [11:0] termination_current_limit_o, // mA
  output logic [12:0] regulation_voltage_o,        // mV
  output logic [11:0] precharge_threshold_o,       // mV
  output logic [12:0] recharge_threshold_o,        // mV
  output logic term_enable_o,              // termination enabled
  output logic [11:0] stat_threshold_o,    // status indication current, mA
  output logic [7:0] watchdog_period_o,    // seconds, zero when off
  output logic timer_enable_o,             // safety timer enabled
  output logic [4:0] fast_charge_timer_period_o    // hours
);

  ctc_pkg::ctc_top_s st_q;
  ctc_pkg::ctc_top_s st_d;
  ctc_pkg::ctc_dec_s dec;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] rd_byte;

  localparam logic [7:0] CHG_VOLT_RST = REDUCED_VARIANT ? `CTC_RST_CHG_VOLT_RED : `CTC_RST_CHG_VOLT_STD;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_read(input logic [7:0] ptr, input ctc_pkg::ctc_top_s s);
    logic [7:0] v;
    v = 8'h00;
    if (ptr == `CTC_OFS_PRECHG_TERM) begin
      v = s.prechg_term;
    end else if (ptr == `CTC_OFS_CHG_VOLT) begin
      v = s.chg_volt;
    end else if (ptr == `CTC_OFS_TERM_TIMER) begin
      v = s.term_timer;
    end
    return v;
  endfunction : reg_read

  // ----------------------------------------------------------------
  // bus conditions
  // ----------------------------------------------------------------
  assign scl_rise = scl_i & ~st_q.scl;
  assign scl_fall = ~scl_i & st_q.scl;
  assign start_cond = scl_i & st_q.scl & st_q.sda & ~sda_i;
  assign stop_cond = scl_i & st_q.scl & ~st_q.sda & sda_i;
  assign rd_byte = reg_read(st_q.ptr, st_q);                                     // R18

  // ----------------------------------------------------------------
  // target engine and register store
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.scl = scl_i;
    st_d.sda = sda_i;
    if (start_cond) begin
      st_d.state = ctc_pkg::CTC_ADDR;
      st_d.bit_cnt = 4'h0;
      st_d.sda_oe = 1'b0;
    end else if (stop_cond) begin
      st_d.state = ctc_pkg::CTC_IDLE;
      st_d.sda_oe = 1'b0;
    end else begin
      case (st_q.state)
        ctc_pkg::CTC_ADDR, ctc_pkg::CTC_PTR, ctc_pkg::CTC_WDATA: begin
          if (scl_rise) begin
            st_d.shift = {st_q.shift[6:0], sda_i};
            st_d.bit_cnt = st_q.bit_cnt + 4'h1;
          end else if (scl_fall && (st_q.bit_cnt == `CTC_BYTE_BITS)) begin
            st_d.bit_cnt = 4'h0;
            st_d.sda_oe = 1'b1;
            if (st_q.state == ctc_pkg::CTC_ADDR) begin
              if (st_q.shift[7:1] == I2C_ADDR) begin
                st_d.rw = st_q.shift[0];
                st_d.state = ctc_pkg::CTC_ADDR_ACK;
              end else begin
                st_d.sda_oe = 1'b0;
                st_d.state = ctc_pkg::CTC_IDLE;
              end
            end else if (st_q.state == ctc_pkg::CTC_PTR) begin
              st_d.ptr = st_q.shift;
              st_d.state = ctc_pkg::CTC_PTR_ACK;
            end else begin
              // all bits stored as written, reserved bit included
              if (st_q.ptr == `CTC_OFS_PRECHG_TERM) begin
                st_d.prechg_term = st_q.shift;                                   // R2
              end else if (st_q.ptr == `CTC_OFS_CHG_VOLT) begin
                st_d.chg_volt = st_q.shift;                                      // R6
              end else if (st_q.ptr == `CTC_OFS_TERM_TIMER) begin
                st_d.term_timer = st_q.shift;                                    // R12 R13 R16
              end
              st_d.ptr = st_q.ptr + 8'h01;
              st_d.state = ctc_pkg::CTC_WDATA_ACK;
            end
          end
        end
        ctc_pkg::CTC_ADDR_ACK: begin
          if (scl_fall) begin
            if (st_q.rw) begin
              st_d.shift = rd_byte;
              st_d.ptr = st_q.ptr + 8'h01;
              st_d.sda_oe = ~rd_byte[7];
              st_d.rd_ack = 1'b0;
              st_d.state = ctc_pkg::CTC_RDATA;
            end else begin
              st_d.sda_oe = 1'b0;
              st_d.state = ctc_pkg::CTC_PTR;
            end
          end
        end
        ctc_pkg::CTC_PTR_ACK, ctc_pkg::CTC_WDATA_ACK: begin
          if (scl_fall) begin
            st_d.sda_oe = 1'b0;
            st_d.state = ctc_pkg::CTC_WDATA;
          end
        end
        ctc_pkg::CTC_RDATA: begin
          if (!st_q.rd_ack) begin
            if (scl_fall) begin
              st_d.bit_cnt = st_q.bit_cnt + 4'h1;
              if (st_q.bit_cnt == 4'h7) begin
                st_d.sda_oe = 1'b0;
                st_d.rd_ack = 1'b1;
              end else begin
                st_d.shift = {st_q.shift[6:0], 1'b0};
                st_d.sda_oe = ~st_q.shift[6];
              end
            end
          end else if (scl_rise) begin
            st_d.nack = sda_i;
          end else if (scl_fall) begin
            st_d.bit_cnt = 4'h0;
            if (st_q.nack) begin
              st_d.state = ctc_pkg::CTC_IDLE;
            end else begin
              st_d.shift = rd_byte;
              st_d.ptr = st_q.ptr + 8'h01;
              st_d.sda_oe = ~rd_byte[7];
              st_d.rd_ack = 1'b0;
            end
          end
        end
        default: begin
          st_d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_q <= '0;
      st_q.state <= ctc_pkg::CTC_IDLE;
      st_q.scl <= 1'b1;
      st_q.sda <= 1'b1;
      st_q.prechg_term <= `CTC_RST_PRECHG_TERM;                                  // R1
      st_q.chg_volt <= CHG_VOLT_RST;                                             // R8
      st_q.term_timer <= `CTC_RST_TERM_TIMER;                                    // R11
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // set point decoder
  // ----------------------------------------------------------------
  ctc_cfg_if cfg_bus ();
  assign cfg_bus.prechg_term = st_q.prechg_term;
  assign cfg_bus.chg_volt = st_q.chg_volt;
  assign cfg_bus.term_timer = st_q.term_timer;

  ctc_cfg_decode #(
    .REDUCED_VARIANT(REDUCED_VARIANT)
  ) u_decode (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .cfg(cfg_bus),
    .dec_o(dec)
  );

  assign sda_o = 1'b0;
  assign sda_oe_o = st_q.sda_oe;
  assign prechg_term_o = st_q.prechg_term;
  assign chg_volt_o = st_q.chg_volt;
  assign term_timer_o = st_q.term_timer;
  assign precharge_current_limit_o = dec.prechg_ma;
  assign termination_current_limit_o = dec.term_ma;
  assign regulation_voltage_o = dec.rvolt_mv;
  assign precharge_threshold_o = dec.batlow_mv;
  assign recharge_threshold_o = dec.rechg_mv;
  assign term_enable_o = dec.term_en;
  assign stat_threshold_o = dec.stat_ma;
  assign watchdog_period_o = dec.wdog_s;
  assign timer_enable_o = dec.timer_en;
  assign fast_charge_timer_period_o = dec.timer_h;

endmodule : ctc_charge_cfg

// >>> test/ctc_charge_cfg_asserts.sv
/*
  Concurrent checks on the ports of the charge threshold configuration bank.
  Assumes a single ref_clk_i domain with srst_i as synchronous reset.
*/
`timescale 1ns/100ps
module ctc_charge_cfg_asserts #(
  parameter bit REDUCED_VARIANT = 1'b0
) (
  input wire logic ref_clk_i,                          // clock
  input wire logic srst_i,                             // sync reset
  input wire logic scl_i,                              // i2c clock
  input wire logic sda_oe_o,                           // data pull enable
  input wire logic [7:0] prechg_term_o,                // raw byte
  input wire logic [7:0] chg_volt_o,                   // raw byte
  input wire logic [7:0] term_timer_o,                 // raw byte
  input wire logic [11:0] precharge_current_limit_o,   // mA
  input wire logic [11:0] termination_current_limit_o, // mA
  input wire logic [12:0] regulation_voltage_o,        // mV
  input wire logic [11:0] precharge_threshold_o,       // mV
  input wire logic [12:0] recharge_threshold_o,        // mV
  input wire logic term_enable_o,                      // flag
  input wire logic [11:0] stat_threshold_o,            // mA
  input wire logic [7:0] watchdog_period_o,            // s
  input wire logic timer_enable_o,                     // flag
  input wire logic [4:0] fast_charge_timer_period_o    // hours
);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [11:0] ma(input logic [3:0] c);
    return {8'h00, c} * 12'h080 + 12'h080;
  endfunction : ma
  function automatic logic [3:0] cap(input logic [3:0] c);
    return (REDUCED_VARIANT && c > 4'h4) ? 4'h4 : c;
  endfunction : cap
  function automatic logic [12:0] mv(input logic [5:0] c);
    return 13'h0DB0 + 13'h0010 * {7'h00, (c > 6'h38) ? 6'h38 : c};
  endfunction : mv

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence scl_high3;
    (scl_i && !srst_i) [*3];
  endsequence
  reset_values_a: assert property (disable iff (1'b0) srst_i |=> prechg_term_o == 8'h11 &&
    chg_volt_o == (REDUCED_VARIANT ? 8'h9A : 8'hB2) && term_timer_o == 8'h9A) else $error("bad reset value");
  prechg_dec_a: assert property (1'b1 |=>
    precharge_current_limit_o == ma(cap($past(prechg_term_o[7:4])))) else $error("bad precharge limit");
  term_dec_a: assert property (1'b1 |=>
    termination_current_limit_o == ma($past(prechg_term_o[3:0]))) else $error("bad termination limit");
  volt_dec_a: assert property (1'b1 |=> regulation_voltage_o == mv($past(chg_volt_o[7:2])))
    else $error("bad regulation voltage");
  batlow_dec_a: assert property (1'b1 |=>
    precharge_threshold_o == ($past(chg_volt_o[1]) ? 12'hBB8 : 12'hAF0)) else $error("bad precharge threshold");
  rechg_dec_a: assert property (1'b1 |=> recharge_threshold_o ==
    regulation_voltage_o - ($past(chg_volt_o[0]) ? 13'h012C : 13'h0064)) else $error("bad recharge threshold");
  stat_sel_a: assert property (1'b1 |=> stat_threshold_o ==
    ($past(term_timer_o[6]) ? 12'h320 : termination_current_limit_o)) else $error("bad status threshold");
  timer_fields_a: assert property (1'b1 |=> term_enable_o == $past(term_timer_o[7]) &&
    timer_enable_o == $past(term_timer_o[3]) &&
    watchdog_period_o == (8'h14 << $past(term_timer_o[5:4])) * {7'h00, $past(term_timer_o[5:4]) != 2'b00} &&
    fast_charge_timer_period_o == ($past(term_timer_o[2]) ? ($past(term_timer_o[1]) ? 5'h14 : 5'h0C)
    : ($past(term_timer_o[1]) ? 5'h08 : 5'h05))) else $error("bad timer fields");
  raw_quiet_a: assert property (scl_high3 |-> $stable({prechg_term_o, chg_volt_o, term_timer_o}))
    else $error("register changed with scl high");
  oe_quiet_a: assert property (scl_high3 |-> $stable(sda_oe_o))
    else $error("sda enable changed with scl high");
endmodule : ctc_charge_cfg_asserts

bind ctc_charge_cfg ctc_charge_cfg_asserts #(.REDUCED_VARIANT(REDUCED_VARIANT)) chk (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
  .prechg_term_o(prechg_term_o), .chg_volt_o(chg_volt_o), .term_timer_o(term_timer_o),
  .precharge_current_limit_o(precharge_current_limit_o), .termination_current_limit_o(termination_current_limit_o),
  .regulation_voltage_o(regulation_voltage_o), .precharge_threshold_o(precharge_threshold_o),
  .recharge_threshold_o(recharge_threshold_o), .term_enable_o(term_enable_o), .stat_threshold_o(stat_threshold_o),
  .watchdog_period_o(watchdog_period_o), .timer_enable_o(timer_enable_o),
  .fast_charge_timer_period_o(fast_charge_timer_period_o));

// >>> test/ctc_host_model.sv
/*
  Host side of the management port: an I2C controller driving scl and sda.
  Assumes sda is a pulled-up wire resolved by the testbench.
*/
`timescale 1ns/100ps
module ctc_host_model (
  input wire logic clk_i,   // bench clock
  input wire logic sda_i,   // resolved data wire
  output logic scl_o,       // i2c clock
  output logic sda_o        // low pulls the wire down
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
  endtask : hold
  task automatic start;
    sda_o = 1'b1; hold(2); scl_o = 1'b1; hold(4); sda_o = 1'b0; hold(4); scl_o = 1'b0; hold(2);
  endtask : start
  task automatic stop;
    sda_o = 1'b0; hold(2); scl_o = 1'b1; hold(4); sda_o = 1'b1; hold(4);
  endtask : stop
  task automatic bitw(input logic b);
    sda_o = b; hold(2); scl_o = 1'b1; hold(4); scl_o = 1'b0; hold(2);
  endtask : bitw
  // msb first, then sample the target's acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bitw(b[i]);
    sda_o = 1'b1; hold(2); scl_o = 1'b1; hold(2); ack = (sda_i === 1'b0); hold(2); scl_o = 1'b0; hold(2);
  endtask : wbyte
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ack);
    logic a0, a1, a2;
    start(); wbyte({a, 1'b0}, a0); wbyte(p, a1); wbyte(d, a2); stop();
    ack = a0 & a1 & a2;
  endtask : wr
  // single byte read, ended by a not-acknowledge
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d, output logic ack);
    logic a0, a1, a2;
    start(); wbyte({a, 1'b0}, a0); wbyte(p, a1); start(); wbyte({a, 1'b1}, a2);
    sda_o = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      hold(2); scl_o = 1'b1; hold(2); d[i] = sda_i; hold(2); scl_o = 1'b0; hold(2);
    end
    bitw(1'b1); stop();
    ack = a0 & a1 & a2;
  endtask : rd
endmodule : ctc_host_model

// >>> test/charge_threshold_config_regs_test.sv
/*
  Self-checking bench for the charge threshold configuration bank.
  Assumes the host model drives the management port and sda has a pull-up.
*/
`timescale 1ns/100ps
module charge_threshold_config_regs_test;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic scl, sda_m, sda_o, sda_oe_o, ack, t_en, tm_en, oe_red;
  wire logic sda = sda_m & ~sda_oe_o & ~oe_red;
  logic [7:0] r3, r4, r5, d, p, v, r4_red;
  logic [7:0] m [3:5];
  logic [11:0] pc, tc, bl, st, pc_red;
  logic [12:0] rv, rc;
  logic [7:0] wd;
  logic [4:0] th;
  logic [15:0] wd_t [4] = '{16'h0000, 16'h0028, 16'h0050, 16'h00A0};
  logic [15:0] th_t [4] = '{16'h0005, 16'h0008, 16'h000C, 16'h0014};
  logic [7:0] crn [6] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFE, 8'h00};
  int n_fail = 0;
  int comparisons = 0;
  localparam logic [6:0] ADDR = 7'h2A;

  initial forever #25 ref_clk_i = ~ref_clk_i;

  ctc_host_model host (.clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
  ctc_charge_cfg #(.I2C_ADDR(ADDR), .REDUCED_VARIANT(1'b0)) uut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .prechg_term_o(r3), .chg_volt_o(r4), .term_timer_o(r5), .precharge_current_limit_o(pc),
    .termination_current_limit_o(tc), .regulation_voltage_o(rv), .precharge_threshold_o(bl),
    .recharge_threshold_o(rc), .term_enable_o(t_en), .stat_threshold_o(st), .watchdog_period_o(wd),
    .timer_enable_o(tm_en), .fast_charge_timer_period_o(th));
  ctc_charge_cfg #(.I2C_ADDR(7'h2C), .REDUCED_VARIANT(1'b1)) uut_red (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(oe_red),
    .prechg_term_o(), .chg_volt_o(r4_red), .term_timer_o(), .precharge_current_limit_o(pc_red),
    .termination_current_limit_o(), .regulation_voltage_o(), .precharge_threshold_o(),
    .recharge_threshold_o(), .term_enable_o(), .stat_threshold_o(), .watchdog_period_o(),
    .timer_enable_o(), .fast_charge_timer_period_o());

  // ----------------------------------------------------------------
  // expectations and comparison
  // ----------------------------------------------------------------
  function automatic logic [15:0] ma(input logic [3:0] c);
    return ({12'h000, c} + 16'h0001) * 16'h0080;
  endfunction : ma
  function automatic logic [15:0] mv(input logic [5:0] c);
    return 16'h0DB0 + 16'h0010 * {10'h000, (c > 6'h38) ? 6'h38 : c};
  endfunction : mv
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic check_all;
    chk("prechg_term", {8'h00, m[3]}, {8'h00, r3});
    chk("chg_volt", {8'h00, m[4]}, {8'h00, r4});
    chk("term_timer", {8'h00, m[5]}, {8'h00, r5});
    chk("prechg_ma", ma(m[3][7:4]), {4'h0, pc});
    chk("term_ma", ma(m[3][3:0]), {4'h0, tc});
    chk("reg_volt_mv", mv(m[4][7:2]), {3'h0, rv});
    chk("batlow_mv", m[4][1] ? 16'h0BB8 : 16'h0AF0, {4'h0, bl});
    chk("rechg_mv", mv(m[4][7:2]) - (m[4][0] ? 16'h012C : 16'h0064), {3'h0, rc});
    chk("term_en", {15'h0000, m[5][7]}, {15'h0000, t_en});
    chk("stat_ma", m[5][6] ? 16'h0320 : ma(m[3][3:0]), {4'h0, st});
    chk("wdog_s", wd_t[m[5][5:4]], {8'h00, wd});
    chk("timer_en", {15'h0000, m[5][3]}, {15'h0000, tm_en});
    chk("timer_h", th_t[m[5][2:1]], {11'h000, th});
  endtask : check_all
  task automatic access(input logic [7:0] pt, input logic [7:0] val);
    host.wr(ADDR, pt, val, ack);
    chk("write_ack", 16'h0001, {15'h0000, ack});
    m[pt] = val;
    check_all();
    host.rd(ADDR, pt, d, ack);
    chk("readback", {8'h00, val}, {8'h00, d});
    chk("read_ack", 16'h0001, {15'h0000, ack});
  endtask : access
  task automatic set_reset_model;
    m[3] = 8'h11;
    m[4] = 8'hB2;
    m[5] = 8'h9A;
  endtask : set_reset_model
  task automatic summarize;
    $display("n_fail %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(40));
    set_reset_model();
    repeat (5) @(negedge ref_clk_i);
    srst_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    check_all();
    chk("red_chg_volt", 16'h009A, {8'h00, r4_red});
    chk("sda_o", 16'h0000, {15'h0000, sda_o});
    for (int i = 3; i <= 5; i++) begin
      host.rd(ADDR, 8'(i), d, ack);
      chk("reset_read", {8'h00, m[i]}, {8'h00, d});
    end
    for (int i = 0; i < 18; i++) begin
      p = (i < 6) ? 8'h03 + 8'(i / 2) : 8'h03 + 8'($urandom % 3);
      v = (i < 6) ? crn[i] : 8'($urandom);
      if (p == 8'h05) v[0] = 1'b0;
      access(p, v);
    end
    host.wr(7'h2B, 8'h03, 8'h5A, ack);
    chk("foreign_ack", 16'h0000, {15'h0000, ack});
    check_all();
    host.wr(7'h2C, 8'h03, 8'hF0, ack);
    chk("red_ack", 16'h0001, {15'h0000, ack});
    chk("red_prechg_ma", 16'h0280, {4'h0, pc_red});
    host.rd(ADDR, 8'h07, d, ack);
    chk("unmapped_read", 16'h0000, {8'h00, d});
    srst_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    srst_i = 1'b0;
    set_reset_model();
    repeat (3) @(negedge ref_clk_i);
    check_all();
    summarize();
  end

  initial begin
    repeat (60000) @(posedge ref_clk_i);
    n_fail++;
    summarize();
  end
endmodule : charge_threshold_config_regs_test
